// ==== verilog/uct_pkg.sv ====
// uct_pkg: constants, formats and state types of the character
// format control, transmitter and receiver block.
// assumes a single 50 MHz clock domain; the 16x bit clock is sampled.
package uct_pkg;

    // clock and bit timing
    localparam int unsigned CLOCK_HZ = 50000000;
    localparam int unsigned TICKS_PER_BIT = 16;
    localparam logic [3:0] PHASE_LAST = 4'hf;
    localparam logic [3:0] PHASE_MID = 4'h7;
    localparam logic [3:0] PHASE_RESET = 4'h0;
    // last data bit index is this base plus the two length bits
    localparam logic [2:0] DATA_LAST_BASE = 3'h4;

    // register byte offsets
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_MASK = 8'h08;
    localparam logic [7:0] REG_RX_DATA = 8'h0c;

    // interrupt event bits
    localparam int EV_TX_EMPTY = 0;
    localparam int EV_CHAR_SENT = 1;
    localparam int EV_RX_AVAIL = 2;
    localparam int EV_RX_ERROR = 3;
    localparam int EV_COUNT = 4;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
    localparam logic [3:0] IRQ_STATUS_RESET = 4'h0;
    localparam logic [7:0] DATA_RESET = 8'h00;

    typedef struct packed {
        logic parity_omit;
        logic stop_count_sel;
        logic char_len_hi;
        logic char_len_lo;
        logic parity_sense;
    } uct_fmt_type;

    localparam uct_fmt_type FMT_RESET = 5'h00;

    typedef struct packed {
        logic tx_holding_empty;
        logic tx_idle;
        logic end_of_char;
        logic rx_data_avail;
        logic parity_err_flag;
        logic framing_err_flag;
        logic rx_overrun_flag;
    } uct_status_type;

    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP}
        uct_tx_state_type;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP}
        uct_rx_state_type;

endpackage : uct_pkg

// ==== verilog/uct_rise_det.sv ====
// uct_rise_det: one-cycle pulse on a rising level of a sampled input.
// assumes the input is synchronous to clock.
`timescale 1ns/10ps
module uct_rise_det
    import uct_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // level in, pulse out
    input wire logic level_in,
    output logic rise
);

    logic level_prev;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            level_prev <= 1'b0;
        end else begin
            level_prev <= level_in;
        end
    end

    assign rise = level_in & ~level_prev;

endmodule : uct_rise_det

// ==== verilog/uct_char_parity.sv ====
// uct_char_parity: parity bit for a 5 to 8 bit character.
// assumes unused high data bits may hold anything; they are masked.
`timescale 1ns/10ps
module uct_char_parity
    import uct_pkg::*;
(
    // character and format
    input wire logic [7:0] data,
    input wire logic [1:0] char_len,
    input wire logic parity_sense,
    // parity bit to send or expect
    output logic parity_bit
);

    logic [7:0] len_mask;

    assign len_mask = 8'hff >> (2'h3 - char_len);
    // even sense: bit makes ones even; odd sense: ones odd
    assign parity_bit = (^(data & len_mask)) ^ ~parity_sense;

endmodule : uct_char_parity

// ==== verilog/uct_top.sv ====
// uct_top: format control holding register, transmitter, receiver,
// status and interrupt registers on a plain register port.
// assumes all inputs synchronous to clock; 16x bit clock is a level.
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/10ps

// How it works
// - parity_omit high drops parity; stop bits follow last data bit
// - parity_omit high skips receive parity check, error flag low
// - stop_count_sel low sends one stop bit, high sends two
// - length bits 00,01,10,11 give 5,6,7,8 data bits, hi bit MSB
// - parity_sense low gives odd parity, high even, sent and checked
// - ext_reset sets line, idle, end flags high; clears rx flags
// - tx_holding_empty high when the transmitter takes the held char, unless a load comes in that cycle
// - data loads on rising data strobe; host holds data valid then
// - end_of_char rises after stop bits, falls at next start edge
// - serial output sends whole character, rests high when idle
// - short characters use low data bits, bit one first, high=mark
// - control strobe level loads format controls; may be tied high
module uct_top
    import uct_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ext_reset,
    // format controls
    input wire logic parity_omit,
    input wire logic stop_count_sel,
    input wire logic char_len_hi,
    input wire logic char_len_lo,
    input wire logic parity_sense,
    input wire logic control_strobe,
    // transmitter
    input wire logic tx_clock_16x,
    input wire logic [7:0] tx_parallel_data,
    input wire logic data_load_strobe,
    output logic tx_holding_empty,
    output logic tx_serial_line,
    output logic tx_idle,
    output logic end_of_char,
    // receiver
    input wire logic rx_serial_line,
    output logic rx_data_avail,
    output logic parity_err_flag,
    output logic framing_err_flag,
    output logic rx_overrun_flag,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    output logic irq
);

    uct_fmt_type fmt_in;
    uct_fmt_type ctl;
    uct_fmt_type tx_fmt;
    uct_fmt_type rx_fmt;
    uct_tx_state_type tx_state;
    uct_tx_state_type next_tx_state;
    uct_rx_state_type rx_state;
    uct_rx_state_type next_rx_state;
    uct_status_type status;
    logic tick;
    logic ds_rise;
    logic [3:0] tx_phase;
    logic [2:0] tx_idx;
    logic [7:0] tx_shift;
    logic [7:0] hold_data;
    logic tx_par;
    logic hold_par;
    logic stop_second;
    logic tx_bit_end;
    logic tx_start;
    logic tx_done;
    logic [2:0] tx_last;
    logic next_line;
    logic [3:0] rx_phase;
    logic [2:0] rx_idx;
    logic [7:0] rx_shift;
    logic [7:0] rx_data;
    logic rx_par_bit;
    logic rx_par_expect;
    logic [2:0] rx_last;
    logic rx_bit_end;
    logic rx_done;
    logic rx_take;
    logic rx_perr;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic [3:0] events;
    logic [3:0] pending_bits;
    logic pending;
    logic wr_irq_status;
    logic wr_irq_mask;
    logic [31:0] read_mux;

    uct_rise_det u_tick (
        .clock(clock),
        .rst_n(rst_n),
        .level_in(tx_clock_16x),
        .rise(tick)
    );

    uct_rise_det u_ds (
        .clock(clock),
        .rst_n(rst_n),
        .level_in(data_load_strobe),
        .rise(ds_rise)
    );

    // parity of the holding register, fixed when the character starts
    uct_char_parity u_tx_par (
        .data(hold_data),
        .char_len({ctl.char_len_hi, ctl.char_len_lo}),
        .parity_sense(ctl.parity_sense),
        .parity_bit(hold_par)
    );

    uct_char_parity u_rx_par (
        .data(rx_shift),
        .char_len({rx_fmt.char_len_hi, rx_fmt.char_len_lo}),
        .parity_sense(rx_fmt.parity_sense),
        .parity_bit(rx_par_expect)
    );

    // format control holding register
    assign fmt_in = '{parity_omit, stop_count_sel, char_len_hi,
                      char_len_lo, parity_sense};

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctl <= FMT_RESET;
        end else if (control_strobe) begin
            ctl <= fmt_in;
        end
    end

    // transmitter decode
    assign tx_last = DATA_LAST_BASE
                     + {1'b0, tx_fmt.char_len_hi, tx_fmt.char_len_lo};
    assign tx_bit_end = tick && (tx_phase == PHASE_LAST);
    assign tx_start = tick && (tx_state == TX_IDLE) && !tx_holding_empty;
    assign tx_done = tx_bit_end && (tx_state == TX_STOP) && !stop_second;

    always_comb begin
        next_tx_state = tx_state;
        next_line = tx_serial_line;
        case (tx_state)
            TX_IDLE: begin
                next_line = 1'b1;
                if (tx_start) begin
                    next_tx_state = TX_START;
                    next_line = 1'b0;
                end
            end
            TX_START: begin
                if (tx_bit_end) begin
                    next_tx_state = TX_DATA;
                    next_line = tx_shift[0];
                end
            end
            TX_DATA: begin
                if (tx_bit_end && tx_idx != tx_last) begin
                    next_line = tx_shift[1];
                end else if (tx_bit_end && tx_fmt.parity_omit) begin
                    next_tx_state = TX_STOP;
                    next_line = 1'b1;
                end else if (tx_bit_end) begin
                    next_tx_state = TX_PARITY;
                    next_line = tx_par;
                end
            end
            TX_PARITY: begin
                if (tx_bit_end) begin
                    next_tx_state = TX_STOP;
                    next_line = 1'b1;
                end
            end
            TX_STOP: begin
                next_line = 1'b1;
                if (tx_done) begin
                    next_tx_state = TX_IDLE;
                end
            end
            default: begin
                next_tx_state = TX_IDLE;
                next_line = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_state <= TX_IDLE;
            tx_serial_line <= 1'b1;
        end else if (ext_reset) begin
            tx_state <= TX_IDLE;
            tx_serial_line <= 1'b1;
        end else begin
            tx_state <= next_tx_state;
            tx_serial_line <= next_line;
        end
    end

    // bit phase, data index, shifter and per-character format
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_phase <= PHASE_RESET;
            tx_idx <= 3'h0;
            tx_shift <= DATA_RESET;
            tx_fmt <= FMT_RESET;
            tx_par <= 1'b0;
            stop_second <= 1'b0;
        end else if (tx_start) begin
            tx_phase <= PHASE_RESET;
            tx_idx <= 3'h0;
            tx_shift <= hold_data;
            tx_fmt <= ctl;
            tx_par <= hold_par;
            stop_second <= ctl.stop_count_sel;
        end else if (tick && tx_state != TX_IDLE) begin
            tx_phase <= tx_phase + 4'h1;
            if (tx_bit_end && tx_state == TX_DATA) begin
                tx_shift <= {1'b0, tx_shift[7:1]};
                tx_idx <= tx_idx + 3'h1;
            end
            if (tx_bit_end && tx_state == TX_STOP) begin
                stop_second <= 1'b0;
            end
        end
    end

    // holding register; a new load wins over the transfer out
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hold_data <= DATA_RESET;
            tx_holding_empty <= 1'b1;
        end else if (ds_rise) begin
            hold_data <= tx_parallel_data;
            tx_holding_empty <= 1'b0;
        end else if (tx_start) begin
            tx_holding_empty <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_idle <= 1'b1;
            end_of_char <= 1'b1;
        end else if (ext_reset) begin
            tx_idle <= 1'b1;
            end_of_char <= 1'b1;
        end else if (tx_start) begin
            tx_idle <= 1'b0;
            end_of_char <= 1'b0;
        end else if (tx_done) begin
            tx_idle <= 1'b1;
            end_of_char <= 1'b1;
        end
    end

    // receiver, sampled on the same 16x ticks
    assign rx_last = DATA_LAST_BASE
                     + {1'b0, rx_fmt.char_len_hi, rx_fmt.char_len_lo};
    assign rx_bit_end = tick && (rx_phase == PHASE_LAST);
    assign rx_done = rx_bit_end && (rx_state == RX_STOP);
    assign rx_perr = !rx_fmt.parity_omit && (rx_par_bit != rx_par_expect);

    always_comb begin
        next_rx_state = rx_state;
        case (rx_state)
            RX_IDLE: begin
                if (tick && !rx_serial_line) begin
                    next_rx_state = RX_START;
                end
            end
            RX_START: begin
                if (tick && rx_phase == PHASE_MID) begin
                    next_rx_state = rx_serial_line ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rx_bit_end && rx_idx == rx_last) begin
                    next_rx_state = rx_fmt.parity_omit ? RX_STOP : RX_PARITY;
                end
            end
            RX_PARITY: begin
                if (rx_bit_end) begin
                    next_rx_state = RX_STOP;
                end
            end
            RX_STOP: begin
                if (rx_bit_end) begin
                    next_rx_state = RX_IDLE;
                end
            end
            default: begin
                next_rx_state = RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_state <= RX_IDLE;
            rx_phase <= PHASE_RESET;
            rx_idx <= 3'h0;
            rx_shift <= DATA_RESET;
            rx_fmt <= FMT_RESET;
            rx_par_bit <= 1'b0;
        end else begin
            rx_state <= next_rx_state;
            if (rx_state == RX_IDLE) begin
                rx_phase <= PHASE_RESET;
                rx_idx <= 3'h0;
                rx_shift <= DATA_RESET;
                rx_fmt <= ctl;
            end else if (rx_state == RX_START && tick
                         && rx_phase == PHASE_MID) begin
                rx_phase <= PHASE_RESET;
            end else if (tick) begin
                rx_phase <= rx_phase + 4'h1;
            end
            if (rx_bit_end && rx_state == RX_DATA) begin
                rx_shift[rx_idx] <= rx_serial_line;
                rx_idx <= rx_idx + 3'h1;
            end
            if (rx_bit_end && rx_state == RX_PARITY) begin
                rx_par_bit <= rx_serial_line;
            end
        end
    end

    // receive flags; a new character wins over the read that takes one
    assign rx_take = reg_read && (reg_addr == REG_RX_DATA);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_data <= DATA_RESET;
            rx_data_avail <= 1'b0;
            parity_err_flag <= 1'b0;
            framing_err_flag <= 1'b0;
            rx_overrun_flag <= 1'b0;
        end else if (ext_reset) begin
            rx_data_avail <= 1'b0;
            parity_err_flag <= 1'b0;
            framing_err_flag <= 1'b0;
            rx_overrun_flag <= 1'b0;
        end else if (rx_done) begin
            rx_data <= rx_shift;
            rx_data_avail <= 1'b1;
            parity_err_flag <= rx_perr;
            framing_err_flag <= !rx_serial_line;
            rx_overrun_flag <= rx_data_avail && !rx_take;
        end else if (rx_take) begin
            rx_data_avail <= 1'b0;
        end
    end

    // interrupt status, write one to clear, set wins
    assign events[EV_TX_EMPTY] = tx_start;
    assign events[EV_CHAR_SENT] = tx_done;
    assign events[EV_RX_AVAIL] = rx_done;
    assign events[EV_RX_ERROR] = rx_done && (rx_perr || !rx_serial_line);
    assign wr_irq_status = reg_write && (reg_addr == REG_IRQ_STATUS);
    assign wr_irq_mask = reg_write && (reg_addr == REG_IRQ_MASK);
    assign pending_bits = irq_status & irq_mask;
    assign pending = |pending_bits;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= IRQ_STATUS_RESET;
            irq_mask <= IRQ_MASK_RESET;
            irq <= 1'b0;
        end else begin
            irq_status <= (irq_status
                           & ~(wr_irq_status ? reg_wdata[3:0] : 4'h0))
                          | events;
            if (wr_irq_mask) begin
                irq_mask <= reg_wdata[3:0];
            end
            irq <= pending;
        end
    end

    // read data, one cycle after the read strobe
    assign status = '{tx_holding_empty, tx_idle, end_of_char, rx_data_avail,
                      parity_err_flag, framing_err_flag, rx_overrun_flag};
    assign read_mux = (reg_addr == REG_STATUS) ? {25'h0, status} :
                      (reg_addr == REG_IRQ_STATUS) ? {28'h0, irq_status} :
                      (reg_addr == REG_IRQ_MASK) ? {28'h0, irq_mask} :
                      (reg_addr == REG_RX_DATA) ? {24'h0, rx_data} :
                      32'h0;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= reg_read ? read_mux : 32'h0;
        end
    end

    // checks
    property p_parity_clamp;
        @(posedge clock) disable iff (!rst_n)
        $rose(parity_err_flag) |-> !rx_fmt.parity_omit;
    endproperty
    a_parity_clamp: assert property (p_parity_clamp)
        else $error("parity error raised with parity omitted");

    property p_parity_skip;
        @(posedge clock) disable iff (!rst_n)
        rx_done && rx_fmt.parity_omit && !ext_reset |=> !parity_err_flag;
    endproperty
    a_parity_skip: assert property (p_parity_skip)
        else $error("parity error flagged on a frame without parity");

    property p_omit_skip;
        @(posedge clock) disable iff (!rst_n)
        tx_state == TX_DATA && next_tx_state != TX_DATA && !ext_reset
        |-> (next_tx_state == TX_STOP) == tx_fmt.parity_omit;
    endproperty
    a_omit_skip: assert property (p_omit_skip)
        else $error("parity bit not omitted or not sent as selected");

    property p_ext_reset;
        @(posedge clock) disable iff (!rst_n)
        ext_reset |=> tx_serial_line && tx_idle && end_of_char
            && !rx_data_avail && !parity_err_flag && !framing_err_flag
            && !rx_overrun_flag;
    endproperty
    a_ext_reset: assert property (p_ext_reset)
        else $error("external reset left a flag wrong");

    property p_load;
        @(posedge clock) disable iff (!rst_n)
        ds_rise |=> !tx_holding_empty && hold_data == $past(tx_parallel_data);
    endproperty
    a_load: assert property (p_load)
        else $error("data strobe edge did not load holding register");

    property p_ctl_load;
        @(posedge clock) disable iff (!rst_n)
        control_strobe |=> ctl == $past(fmt_in);
    endproperty
    a_ctl_load: assert property (p_ctl_load)
        else $error("control strobe did not load format");

    property p_eoc_fall;
        @(posedge clock) disable iff (!rst_n)
        $fell(end_of_char) |-> $fell(tx_serial_line) && !tx_idle;
    endproperty
    a_eoc_fall: assert property (p_eoc_fall)
        else $error("end of character fell away from a start edge");

    property p_idle_mark;
        @(posedge clock) disable iff (!rst_n)
        tx_state == TX_IDLE || tx_state == TX_STOP |-> tx_serial_line;
    endproperty
    a_idle_mark: assert property (p_idle_mark)
        else $error("serial output low while idle or in stop bit");

    property p_bit_hold;
        @(posedge clock) disable iff (!rst_n)
        tx_state != TX_IDLE && !tx_bit_end && !ext_reset
        |=> $stable(tx_serial_line);
    endproperty
    a_bit_hold: assert property (p_bit_hold)
        else $error("serial output changed inside a bit time");

    property p_parity_bit;
        @(posedge clock) disable iff (!rst_n)
        tx_state == TX_PARITY |-> tx_serial_line == tx_par;
    endproperty
    a_parity_bit: assert property (p_parity_bit)
        else $error("parity bit on the line differs from computed");

    property p_irq;
        @(posedge clock) disable iff (!rst_n)
        ##1 irq == $past(pending);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt output does not follow masked status");

endmodule : uct_top

// ==== sim/uct_far_side.sv ====
// uct_far_side: 16x tick source and serial line partner of uct_top.
// assumes the serial output is looped back to the serial input.
`timescale 1ns/10ps
module uct_far_side (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // serial line
    input wire logic tx_serial_line,
    output logic tx_clock_16x,
    output logic rx_serial_line
);
    logic half;
    // tick: two clocks high, two low
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            half <= 1'b0;
            tx_clock_16x <= 1'b0;
        end else begin
            half <= ~half;
            if (half)
                tx_clock_16x <= ~tx_clock_16x;
        end
    end
    // mark while in reset, then the looped line, which rests high
    assign rx_serial_line = rst_n ? tx_serial_line : 1'b1;
endmodule : uct_far_side

// ==== sim/tb.sv ====
// tb: frame, flag and interrupt checks of uct_top.
// assumes uct_far_side loops the serial line and makes the tick.
`timescale 1ns/10ps
module tb
    import uct_pkg::*;
;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic ext_reset = 1'b0;
    uct_fmt_type fmt = FMT_RESET;
    logic control_strobe = 1'b0;
    logic [7:0] tx_parallel_data = 8'h00;
    logic data_load_strobe = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic tx_clock_16x, rx_serial_line, tx_holding_empty, tx_serial_line;
    logic tx_idle, end_of_char, rx_data_avail, parity_err_flag, irq;
    logic framing_err_flag, rx_overrun_flag;
    logic [31:0] reg_rdata;
    logic [31:0] r;
    int fails = 0;
    int check_count = 0;
    int cycles = 0;

    always #10 clock = ~clock;

    uct_top u_dut (.clock(clock), .rst_n(rst_n), .ext_reset(ext_reset),
        .parity_omit(fmt.parity_omit), .stop_count_sel(fmt.stop_count_sel),
        .char_len_hi(fmt.char_len_hi), .char_len_lo(fmt.char_len_lo),
        .parity_sense(fmt.parity_sense), .control_strobe(control_strobe),
        .tx_clock_16x(tx_clock_16x), .tx_parallel_data(tx_parallel_data),
        .data_load_strobe(data_load_strobe),
        .tx_holding_empty(tx_holding_empty), .tx_serial_line(tx_serial_line),
        .tx_idle(tx_idle), .end_of_char(end_of_char),
        .rx_serial_line(rx_serial_line), .rx_data_avail(rx_data_avail),
        .parity_err_flag(parity_err_flag),
        .framing_err_flag(framing_err_flag),
        .rx_overrun_flag(rx_overrun_flag), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .irq(irq));

    uct_far_side u_far (.clock(clock), .rst_n(rst_n),
        .tx_serial_line(tx_serial_line), .tx_clock_16x(tx_clock_16x),
        .rx_serial_line(rx_serial_line));

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            summarize();
        end
    end

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_rd

    task automatic load(input logic [7:0] d);
        @(posedge clock);
        tx_parallel_data <= d;
        data_load_strobe <= 1'b1;
        @(posedge clock);
        data_load_strobe <= 1'b0;
        #1 check("holding empty", 0, tx_holding_empty);
    endtask : load

    task automatic bit_at(input string what, input logic exp);
        repeat (64) @(posedge clock);
        #1 check(what, exp, tx_serial_line);
    endtask : bit_at

    task automatic send_frame(input uct_fmt_type f, input logic [7:0] d);
        logic [7:0] m;
        int n;
        int w;
        n = 5 + int'({f.char_len_hi, f.char_len_lo});
        m = d & (8'hff >> (8 - n));
        @(posedge clock);
        fmt <= f;
        control_strobe <= 1'b1;
        @(posedge clock);
        control_strobe <= 1'b0;
        fmt <= ~f;
        load(d);
        w = 0;
        while (tx_serial_line === 1'b1 && w < 300) begin
            @(posedge clock);
            #1 w++;
        end
        repeat (32) @(posedge clock);
        #1 check("start bit", 0, tx_serial_line);
        check("end of char low", 0, end_of_char);
        for (int i = 0; i < n; i++)
            bit_at("data bit", m[i]);
        if (!f.parity_omit)
            bit_at("parity", f.parity_sense ? ^m : ~^m);
        for (int i = 0; i <= int'(f.stop_count_sel); i++)
            bit_at("stop bit", 1'b1);
        check("end of char in stop", 0, end_of_char);
        repeat (40) @(posedge clock);
        #1 check("end of char", 1, end_of_char);
        check("idle line", 3, {tx_idle, tx_serial_line});
        check("parity flag", 0, parity_err_flag);
        reg_rd(REG_RX_DATA, r);
        check("rx data", {24'h0, m}, r);
    endtask : send_frame

    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        #1 check("reset outs", 8'hf0, {tx_serial_line, tx_idle, end_of_char,
            tx_holding_empty, rx_data_avail, parity_err_flag,
            framing_err_flag, rx_overrun_flag});
        reg_wr(REG_IRQ_MASK, 32'h1 << EV_CHAR_SENT);
        for (int i = 0; i < 4; i++)
            send_frame(uct_fmt_type'({i[0], i[0] ^ i[1], i[1:0], i[1]}),
                8'h2c + 8'(i * 71));
        check("irq raised", 1, irq);
        reg_rd(REG_IRQ_STATUS, r);
        check("irq events", 32'h7, r);
        reg_wr(REG_IRQ_MASK, 32'h0);
        @(posedge clock);
        #1 check("irq masked", 0, irq);
        reg_wr(REG_IRQ_STATUS, 32'hf);
        reg_wr(REG_IRQ_MASK, 32'h1 << EV_CHAR_SENT);
        repeat (2) @(posedge clock);
        #1 check("irq cleared", 0, irq);
        reg_rd(REG_STATUS, r);
        check("status", 32'h70, r);
        reg_rd(8'h10, r);
        check("unmapped", 0, r);
        load(8'h00);
        repeat (1200) @(posedge clock);
        #1 check("rx avail", 1, rx_data_avail);
        load(8'h00);
        repeat (700) @(posedge clock);
        load(8'h00);
        repeat (200) @(posedge clock);
        #1 check("overrun", 1, rx_overrun_flag);
        @(posedge clock);
        ext_reset <= 1'b1;
        @(posedge clock);
        ext_reset <= 1'b0;
        #1 check("ext reset outs", 7'h70, {tx_serial_line, tx_idle,
            end_of_char, rx_data_avail, parity_err_flag, framing_err_flag,
            rx_overrun_flag});
        summarize();
    end
endmodule : tb
